// [hw/serr_mask_pkg.sv]
package serr_mask_pkg;

  // configuration dword that holds the mask, byte lane 0
  localparam logic [7:0] MASK_DWORD_ADDR = 8'h64;
  localparam int         MASK_LANE       = 0;
  localparam logic [7:0] MASK_RESET      = 8'h00;
  localparam logic [7:0] MASK_WRITABLE   = 8'h7E;

  // levels that the outputs take while reset is applied
  localparam logic [31:0] RDATA_RESET    = 32'h00000000;
  localparam logic        RVALID_RESET   = 1'b0;
  localparam logic        PIN_IDLE_LEVEL = 1'b1;
  localparam logic        PIN_IDLE_OE    = 1'b0;

  // field positions inside the mask byte
  localparam int BIT_PW_PARITY   = 1;
  localparam int BIT_PW_NODELIV  = 2;
  localparam int BIT_PW_TABORT   = 3;
  localparam int BIT_PW_MABORT   = 4;
  localparam int BIT_DW_NODELIV  = 5;
  localparam int BIT_DR_NODATA   = 6;

  // attempt limit behind the three nondelivery events, as a power of two
  localparam int ATTEMPT_LIMIT_LOG2 = 24;

  // configuration access from the primary bus target logic
  typedef struct packed {
    logic        write;
    logic        read;
    logic [7:0]  dword_addr;
    logic [3:0]  byte_en_n;
    logic [31:0] wdata;
  } cfg_req_t;

  // one-cycle error event pulses, one per source
  typedef struct packed {
    logic dr_nodata;
    logic dw_nodeliv;
    logic pw_mabort;
    logic pw_tabort;
    logic pw_nodeliv;
    logic pw_parity;
  } err_events_t;

endpackage

// [hw/system_error_event_mask.sv]
`timescale 1ns/1ns
// Function
// [R1] posted write target parity error reaches system error unless mask bit 1 set
// [R2] posted write nondelivery after 2^24 attempts reported unless mask bit 2 set
// [R3] target abort during posted write delivery reported unless mask bit 3 set
// [R4] master abort during posted write delivery reported unless mask bit 4 set
// [R5] delayed write nondelivery after 2^24 attempts reported unless mask bit 5 set
// [R6] delayed read without data after 2^24 attempts reported unless mask bit 6 set
// [R7] unmasked events drive system error only when command register enable is set
// [R8] mask bits 0 and 7 read zero and ignore writes
// [R9] mask bits 1 to 6 reset to zero and are software readable and writable
// [R10] mask decoded at dword 64h, byte lane 0 only
// [R11] qualified events merged into one active-low pulse, one clock per event
module system_error_event_mask (
  input  wire logic                      clock,
  input  wire logic                      rst,
  input  wire serr_mask_pkg::cfg_req_t   cfg_req,
  input  wire serr_mask_pkg::err_events_t err_events,
  input  wire logic                      serr_enable,
  output logic [31:0]                    cfg_rdata,
  output logic                           cfg_rvalid,
  output logic                           serr_n_out,
  output logic                           serr_n_oe,
  output logic [7:0]                     mask_value
);

  ////////////////////////////////////////////////////////////////////////////
  // decode helpers

  // address of the access matches the mask dword
  function automatic logic dword_match(input logic [7:0] dword_addr);
    dword_match = (dword_addr == serr_mask_pkg::MASK_DWORD_ADDR);
  endfunction

  // mask lane enabled, byte enables being active low
  function automatic logic lane_enabled(input logic [3:0] byte_en_n);
    lane_enabled = !byte_en_n[serr_mask_pkg::MASK_LANE];
  endfunction

  // true when the access targets the mask byte
  function automatic logic mask_hit(input serr_mask_pkg::cfg_req_t req);
    mask_hit = dword_match(req.dword_addr) && lane_enabled(req.byte_en_n);
  endfunction

  // a source counts only while its disable bit is clear
  function automatic logic source_live(input logic pulse,
                                       input logic masked);
    source_live = pulse && !masked;
  endfunction

  // reserved positions cleared so they never read back as one
  function automatic logic [7:0] writable_only(input logic [7:0] raw);
    writable_only = raw & serr_mask_pkg::MASK_WRITABLE;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // internal signals

  // access qualifiers
  logic       write_hit;
  logic       read_hit;

  // one disable bit per error source, each in a flop of its own
  logic       parity_off_reg;
  logic       post_fail_off_reg;
  logic       target_abort_off_reg;
  logic       master_abort_off_reg;
  logic       delayed_write_off_reg;
  logic       delayed_read_off_reg;

  // next values of the disable bits
  logic       parity_off_next;
  logic       post_fail_off_next;
  logic       target_abort_off_next;
  logic       master_abort_off_next;
  logic       delayed_write_off_next;
  logic       delayed_read_off_next;

  // mask byte as it stands and as the next edge leaves it
  logic [7:0] mask_bits;
  logic [7:0] mask_next;

  // per-source qualified events
  logic       parity_live;
  logic       post_fail_live;
  logic       target_abort_live;
  logic       master_abort_live;
  logic       delayed_write_live;
  logic       delayed_read_live;

  // any live source, then gated by the command register enable
  logic       qualified;
  logic       drive_pin;

  ////////////////////////////////////////////////////////////////////////////
  // access decode

  // only dword 64h with lane 0 enabled reaches the mask
  assign write_hit = cfg_req.write && mask_hit(cfg_req); // [R10]
  assign read_hit  = cfg_req.read && mask_hit(cfg_req);  // [R10]

  ////////////////////////////////////////////////////////////////////////////
  // disable bit next values, replaced together by a hitting write

  // posted write parity error
  always_comb begin
    parity_off_next = parity_off_reg;
    if (write_hit) begin
      parity_off_next = cfg_req.wdata[serr_mask_pkg::BIT_PW_PARITY]; // [R1] [R9]
    end
  end

  // posted write nondelivery
  always_comb begin
    post_fail_off_next = post_fail_off_reg;
    if (write_hit) begin
      post_fail_off_next = cfg_req.wdata[serr_mask_pkg::BIT_PW_NODELIV]; // [R2] [R9]
    end
  end

  // target abort on posted write
  always_comb begin
    target_abort_off_next = target_abort_off_reg;
    if (write_hit) begin
      target_abort_off_next = cfg_req.wdata[serr_mask_pkg::BIT_PW_TABORT]; // [R3] [R9]
    end
  end

  // master abort on posted write
  always_comb begin
    master_abort_off_next = master_abort_off_reg;
    if (write_hit) begin
      master_abort_off_next = cfg_req.wdata[serr_mask_pkg::BIT_PW_MABORT]; // [R4] [R9]
    end
  end

  // delayed write nondelivery
  always_comb begin
    delayed_write_off_next = delayed_write_off_reg;
    if (write_hit) begin
      delayed_write_off_next = cfg_req.wdata[serr_mask_pkg::BIT_DW_NODELIV]; // [R5] [R9]
    end
  end

  // delayed read without data
  always_comb begin
    delayed_read_off_next = delayed_read_off_reg;
    if (write_hit) begin
      delayed_read_off_next = cfg_req.wdata[serr_mask_pkg::BIT_DR_NODATA]; // [R6] [R9]
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // disable bit registers, all clear after reset so every source reports

  // posted write parity error
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      parity_off_reg <= serr_mask_pkg::MASK_RESET[serr_mask_pkg::BIT_PW_PARITY]; // [R9]
    end else begin
      parity_off_reg <= parity_off_next;
    end
  end

  // posted write nondelivery
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      post_fail_off_reg <= serr_mask_pkg::MASK_RESET[serr_mask_pkg::BIT_PW_NODELIV]; // [R9]
    end else begin
      post_fail_off_reg <= post_fail_off_next;
    end
  end

  // target abort on posted write
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      target_abort_off_reg <= serr_mask_pkg::MASK_RESET[serr_mask_pkg::BIT_PW_TABORT]; // [R9]
    end else begin
      target_abort_off_reg <= target_abort_off_next;
    end
  end

  // master abort on posted write
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      master_abort_off_reg <= serr_mask_pkg::MASK_RESET[serr_mask_pkg::BIT_PW_MABORT]; // [R9]
    end else begin
      master_abort_off_reg <= master_abort_off_next;
    end
  end

  // delayed write nondelivery
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      delayed_write_off_reg <= serr_mask_pkg::MASK_RESET[serr_mask_pkg::BIT_DW_NODELIV]; // [R9]
    end else begin
      delayed_write_off_reg <= delayed_write_off_next;
    end
  end

  // delayed read without data
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      delayed_read_off_reg <= serr_mask_pkg::MASK_RESET[serr_mask_pkg::BIT_DR_NODATA]; // [R9]
    end else begin
      delayed_read_off_reg <= delayed_read_off_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // mask byte assembly

  // current mask, reserved bits 0 and 7 have no storage and stay low
  always_comb begin
    mask_bits                                = 8'h00; // [R8]
    mask_bits[serr_mask_pkg::BIT_PW_PARITY]  = parity_off_reg;
    mask_bits[serr_mask_pkg::BIT_PW_NODELIV] = post_fail_off_reg;
    mask_bits[serr_mask_pkg::BIT_PW_TABORT]  = target_abort_off_reg;
    mask_bits[serr_mask_pkg::BIT_PW_MABORT]  = master_abort_off_reg;
    mask_bits[serr_mask_pkg::BIT_DW_NODELIV] = delayed_write_off_reg;
    mask_bits[serr_mask_pkg::BIT_DR_NODATA]  = delayed_read_off_reg;
  end

  // mask after the coming edge, written ones in bits 0 and 7 dropped
  always_comb begin
    mask_next                                = 8'h00; // [R8]
    mask_next[serr_mask_pkg::BIT_PW_PARITY]  = parity_off_next;
    mask_next[serr_mask_pkg::BIT_PW_NODELIV] = post_fail_off_next;
    mask_next[serr_mask_pkg::BIT_PW_TABORT]  = target_abort_off_next;
    mask_next[serr_mask_pkg::BIT_PW_MABORT]  = master_abort_off_next;
    mask_next[serr_mask_pkg::BIT_DW_NODELIV] = delayed_write_off_next;
    mask_next[serr_mask_pkg::BIT_DR_NODATA]  = delayed_read_off_next;
  end

  // registered copy of the mask for the surrounding bridge logic
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      mask_value <= serr_mask_pkg::MASK_RESET; // [R9]
    end else begin
      mask_value <= mask_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // read path, answer one clock after the request

  // read acknowledge for every read request, whatever its address
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      cfg_rvalid <= serr_mask_pkg::RVALID_RESET;
    end else begin
      cfg_rvalid <= cfg_req.read;
    end
  end

  // mask in lane 0 on a hit, zero otherwise; a same-cycle write shows next time
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      cfg_rdata <= serr_mask_pkg::RDATA_RESET;
    end else if (read_hit) begin // [R10]
      cfg_rdata <= {24'h000000, writable_only(mask_bits)}; // [R8]
    end else begin
      cfg_rdata <= 32'h00000000;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // event qualification

  // posted write parity error
  always_comb begin
    parity_live = source_live(err_events.pw_parity, parity_off_reg); // [R1]
  end

  // posted write nondelivery
  always_comb begin
    post_fail_live = source_live(err_events.pw_nodeliv, post_fail_off_reg); // [R2]
  end

  // target abort on posted write
  always_comb begin
    target_abort_live = source_live(err_events.pw_tabort, target_abort_off_reg); // [R3]
  end

  // master abort on posted write
  always_comb begin
    master_abort_live = source_live(err_events.pw_mabort, master_abort_off_reg); // [R4]
  end

  // delayed write nondelivery
  always_comb begin
    delayed_write_live = source_live(err_events.dw_nodeliv, delayed_write_off_reg); // [R5]
  end

  // delayed read without data
  always_comb begin
    delayed_read_live = source_live(err_events.dr_nodata, delayed_read_off_reg); // [R6]
  end

  // several sources in one cycle still give a single low cycle
  assign qualified = parity_live || post_fail_live || target_abort_live ||
                     master_abort_live || delayed_write_live || delayed_read_live; // [R11]

  // nothing reaches the pin while the command register enable is off
  assign drive_pin = qualified && serr_enable; // [R7]

  ////////////////////////////////////////////////////////////////////////////
  // open-drain system error pin, driven low one clock per event

  // pin level, idle high so a released pin never looks asserted
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      serr_n_out <= serr_mask_pkg::PIN_IDLE_LEVEL;
    end else begin
      serr_n_out <= !drive_pin; // [R11]
    end
  end

  // output enable, high only while the pin is pulled low
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      serr_n_oe <= serr_mask_pkg::PIN_IDLE_OE;
    end else begin
      serr_n_oe <= drive_pin; // [R7] [R11]
    end
  end

endmodule // system_error_event_mask

// [test/serr_mask_checker_assertions.sv]
`timescale 1ns/1ns
// watches the mask block ports
module serr_mask_checker (
  input logic                       clock,
  input logic                       rst,
  input serr_mask_pkg::cfg_req_t    cfg_req,
  input serr_mask_pkg::err_events_t err_events,
  input logic                       serr_enable,
  input logic [31:0]                cfg_rdata,
  input logic                       cfg_rvalid,
  input logic                       serr_n_out,
  input logic                       serr_n_oe,
  input logic [7:0]                 mask_value
);
  logic hit;
  logic q;
  // mask decode and qualified event
  assign hit = cfg_req.dword_addr == 8'h64 && !cfg_req.byte_en_n[0];
  assign q = serr_enable && |(err_events & ~mask_value[6:1]);
  default clocking @(posedge clock); endclocking
  default disable iff (rst);
  property p_ev; q |=> !serr_n_out; endproperty
  a_ev: assert property (p_ev) else $error("missing pulse");
  property p_nq; !q |=> !serr_n_oe; endproperty
  a_nq: assert property (p_nq) else $error("stray pulse");
  property p_oe; serr_n_out ^ serr_n_oe; endproperty
  a_oe: assert property (p_oe) else $error("pin mismatch");
  property p_rs; !mask_value[7] && !mask_value[0]; endproperty
  a_rs: assert property (p_rs) else $error("reserved set");
  property p_wr;
    cfg_req.write && hit |=> mask_value == ($past(cfg_req.wdata[7:0]) & 8'h7E);
  endproperty
  a_wr: assert property (p_wr) else $error("bad write");
  property p_nw; !(cfg_req.write && hit) |=> $stable(mask_value); endproperty
  a_nw: assert property (p_nw) else $error("mask moved");
  // read request on the mask, then its answer a clock later
  sequence s_read_hit; cfg_req.read && hit; endsequence
  sequence s_read_answer; cfg_rvalid && cfg_rdata == {24'h0, $past(mask_value)}; endsequence
  property p_rv; s_read_hit |=> s_read_answer; endproperty
  a_rv: assert property (p_rv) else $error("bad read");
  property p_rz; cfg_req.read && !hit |=> cfg_rvalid && cfg_rdata == 32'h0; endproperty
  a_rz: assert property (p_rz) else $error("miss not zero");
  property p_nr; !cfg_req.read |=> !cfg_rvalid; endproperty
  a_nr: assert property (p_nr) else $error("stray valid");
endmodule // serr_mask_checker
bind system_error_event_mask serr_mask_checker u_chk (.clock, .rst, .cfg_req, .err_events,
  .serr_enable, .cfg_rdata, .cfg_rvalid, .serr_n_out, .serr_n_oe, .mask_value);

// [test/cfg_host_model.sv]
`timescale 1ns/1ns
// primary bus configuration master
module cfg_host_model (
  input  logic                    clock,
  output serr_mask_pkg::cfg_req_t cfg_req,
  input  logic [31:0]             cfg_rdata
);
  // one access held a cycle, lines scrambled on release
  task automatic access(input logic [1:0] op, input logic [7:0] a, input logic [3:0] be,
                        input logic [31:0] d, output logic [31:0] r);
    @(negedge clock);
    cfg_req = {op, a, be, d};
    @(negedge clock);
    r = cfg_rdata;
    cfg_req = {2'b00, ~cfg_req[43:0]};
  endtask
  initial cfg_req = '0;
endmodule // cfg_host_model

// [test/system_error_event_mask_tb_top.sv]
`timescale 1ns/1ns
module system_error_event_mask_tb_top;
  logic clock, rst, serr_enable, serr_n_out, serr_n_oe, cfg_rvalid;
  logic [31:0] cfg_rdata, q;
  logic [7:0] mask_value;
  serr_mask_pkg::cfg_req_t cfg_req;
  serr_mask_pkg::err_events_t err_events;
  int mismatches, comparisons;
  system_error_event_mask u_dut (.clock, .rst, .cfg_req, .err_events, .serr_enable,
    .cfg_rdata, .cfg_rvalid, .serr_n_out, .serr_n_oe, .mask_value);
  cfg_host_model u_host (.clock, .cfg_req, .cfg_rdata);
  // compare and count
  task automatic chk(input logic [31:0] g, e);
    comparisons++;
    if (g !== e) begin
      mismatches++;
      $display("ERROR %0t got %h exp %h", $time, g, e);
    end
  endtask
  task automatic complete_run;
    if (mismatches == 0 && comparisons > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  // pulse events, look at the pin a cycle on
  task automatic ev(input logic [5:0] e, input logic h);
    @(negedge clock);
    err_events = e;
    @(negedge clock);
    err_events = '0;
    chk({serr_n_out, serr_n_oe}, h ? 2'b01 : 2'b10);
  endtask
  initial begin
    clock = 0;
    forever #5 clock = ~clock;
  end
  // tests need about 90 clocks, so 2000 clocks means a hang
  initial begin
    repeat (2000) @(posedge clock);
    mismatches++;
    complete_run;
  end
  // register access then event masking
  initial begin
    rst = 1;
    serr_enable = 1;
    err_events = '0;
    repeat (5) @(negedge clock);
    rst = 0;
    u_host.access(2'b01, 8'h64, 4'hE, 0, q);
    chk(q, 0);
    chk(cfg_rvalid, 1);
    u_host.access(2'b10, 8'h64, 4'hE, '1, q);
    chk(cfg_rvalid, 0);
    u_host.access(2'b01, 8'h64, 4'h0, 0, q);
    chk(q, 32'h7E);
    u_host.access(2'b10, 8'h64, 4'h1, 0, q);
    u_host.access(2'b10, 8'h68, 4'hE, 0, q);
    u_host.access(2'b01, 8'h68, 4'hE, 0, q);
    chk(q, 0);
    u_host.access(2'b01, 8'h64, 4'h1, 0, q);
    chk(q, 0);
    chk(cfg_rvalid, 1);
    chk(mask_value, 32'h7E);
    for (int i = 0; i < 6; i++) begin
      u_host.access(2'b10, 8'h64, 4'hE, 0, q);
      ev(6'h01 << i, 1);
      u_host.access(2'b10, 8'h64, 4'hE, 2 << i, q);
      ev(6'h01 << i, 0);
      ev(~(6'h01 << i), 1);
    end
    // mid-run reset clears a full mask and idles the valid, pin, enable and mask outputs
    u_host.access(2'b10, 8'h64, 4'hE, '1, q);
    chk(mask_value, 32'h7E);
    @(negedge clock);
    rst = 1;
    @(negedge clock);
    chk({cfg_rvalid, serr_n_out, serr_n_oe, mask_value}, 11'h200);
    rst = 0;
    u_host.access(2'b01, 8'h64, 4'hE, 0, q);
    chk(q, 0);
    ev(6'h3F, 1);
    serr_enable = 0;
    ev('1, 0);
    complete_run;
  end
endmodule // system_error_event_mask_tb_top
